// ===== core/dag_defines.svh
// constants of the data address generator: offsets, fields, resets
// assumes an 8-bit core with a 12-bit linear data space
//
// Contract
// [R1] indexed literal offset only when extended set
// [R2] far branch carries a 20-bit target
// [R3] opcode low byte is the file address
// [R4] banked access joins bank pointer and byte
// [R5] access bank form ignores the bank pointer
// [R6] full address move ignores bank pointer
// [R7] destination bit picks source register or accumulator
// [R8] pointer pair is 12 bits, high nibble unused
// [R9] plain port accesses memory at the pointer
// [R10] indirect target is the whole 12-bit pointer
// [R11] after-step ports access then step by one
// [R12] before-step port steps then accesses
// [R13] offset port adds signed accumulator to pointer
// [R14] offset port changes neither pointer nor accumulator
// [R15] plain port leaves the pointer unchanged
// [R16] steps carry and borrow across the whole pair
// [R17] pointer steps touch no status flags
// [R18] nested indirect read returns zero
// [R19] nested indirect write does nothing at all
// [R20] own port write to pair stores unstepped value
// [R21] pointer bytes reachable by direct addressing
// [R22] bank address is bank low nibble and byte
`ifndef DAG_DEFINES_SVH
`define DAG_DEFINES_SVH

// per pair, ports count down from the plain port address
`define DAG_PORT_BASE0   12'hFEF
`define DAG_PORT_BASE1   12'hFE7
`define DAG_PORT_BASE2   12'hFDF
`define DAG_PORT_SPAN    12'h007
`define DAG_OFF_PLAIN    3'h0
`define DAG_OFF_UP_AFTER 3'h1
`define DAG_OFF_DN_AFTER 3'h2
`define DAG_OFF_UP_BEFOR 3'h3
`define DAG_OFF_PLUS_ACC 3'h4
`define DAG_OFF_PTR_HIGH 3'h5
`define DAG_OFF_PTR_LOW  3'h6

`define DAG_ACCESS_SPLIT 8'h60
`define DAG_ACCESS_HIGH  4'hF

// register bus byte offsets
`define DAG_REG_CTRL     8'h00
`define DAG_REG_BANK     8'h04
`define DAG_REG_PTR0     8'h08
`define DAG_REG_PTR1     8'h0C
`define DAG_REG_PTR2     8'h10
`define DAG_REG_STATUS   8'h14
`define DAG_CTRL_EXT_BIT 0
`define DAG_STAT_BUSY    0
`define DAG_STAT_ADDR_LO 16

`define DAG_RST_BANK     8'h00
`define DAG_RST_PTR      12'h000
`define DAG_RST_EXT      1'b0

`endif

// ===== core/dag_pkg.sv
// types shared by the data address generator
// assumes dag_defines.svh holds every number
package dag_pkg;

   typedef enum logic [1:0] {
      OP_INHERENT,
      OP_LITERAL,
      OP_DIRECT,
      OP_MOVE
   } dag_op_e;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_RD_WAIT,
      PH_RD_CAP,
      PH_WR
   } dag_phase_e;

   typedef enum logic [1:0] {
      TGT_MEM,
      TGT_PTR,
      TGT_NULL
   } dag_tgt_e;

   typedef struct packed {
      logic       hit;
      logic [1:0] pair;
      logic [2:0] off;
   } dag_loc_s;

   typedef struct packed {
      dag_tgt_e    tgt;
      logic [11:0] addr;
      logic [1:0]  ptr_pair;
      logic        ptr_high;
      logic        do_step;
      logic [1:0]  step_pair;
      logic [11:0] new_ptr;
   } dag_res_s;

   typedef struct packed {
      dag_phase_e       phase;
      logic [2:0][11:0] ptr;
      logic [7:0]       bank;
      logic             ext;
      logic             move;
      logic [11:0]      dst;
      logic [7:0]       acc;
      logic [7:0]       wdata;
      logic [11:0]      mem_addr;
      logic             mem_rd;
      logic             mem_wr;
      logic [7:0]       mem_wdata;
      logic [7:0]       rd_data;
      logic             done;
      logic [19:0]      prog_target;
      logic             dest_src;
      logic             dest_acc;
      logic [11:0]      eff_addr;
      logic             av_ack;
      logic [31:0]      av_rdata;
   } dag_state_s;

endpackage

// ===== core/dag_core.sv
// data address generator: direct, banked and indirect address forming
// assumes a decoder handing one request at a time and a synchronous
// data RAM whose read data is valid the cycle after the read strobe
`timescale 1ns/1ps
`include "dag_defines.svh"

module dag_core
   import dag_pkg::*;
(
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   input  wire logic [7:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic [3:0]  I_AVS_BYTEENABLE,
   output logic      [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   input  wire logic        I_DEC_VALID,
   output logic             O_DEC_READY,
   input  wire logic [1:0]  I_DEC_OP,
   input  wire logic [15:0] I_DEC_OPCODE,
   input  wire logic        I_DEC_BANK_SEL,
   input  wire logic        I_DEC_DEST,
   input  wire logic        I_DEC_WRITE,
   input  wire logic [7:0]  I_DEC_WDATA,
   input  wire logic [7:0]  I_DEC_ACC,
   input  wire logic [19:0] I_DEC_LITERAL,
   input  wire logic [11:0] I_DEC_MOVE_SRC,
   input  wire logic [11:0] I_DEC_MOVE_DST,
   output logic             O_DEC_DONE,
   output logic      [7:0]  O_DEC_RDATA,
   output logic      [19:0] O_PROG_TARGET,
   output logic             O_DEST_SRC,
   output logic             O_DEST_ACC,
   output logic      [11:0] O_EFF_ADDR,
   output logic      [11:0] O_MEM_ADDR,
   output logic             O_MEM_RD,
   output logic             O_MEM_WR,
   output logic      [7:0]  O_MEM_WDATA,
   input  wire logic [7:0]  I_MEM_RDATA
);

   localparam logic [2:0][11:0] PORT_BASE = {`DAG_PORT_BASE2,
                                             `DAG_PORT_BASE1,
                                             `DAG_PORT_BASE0};

   dag_state_s st;
   dag_state_s next_st;

   // which pair and which port an address falls on, if any
   function automatic dag_loc_s locate(input logic [11:0] a);
      dag_loc_s    l;
      logic [11:0] d;
      l = '0;
      for (int n = 0; n < 3; n++) begin
         d = PORT_BASE[n] - a;
         if (d < `DAG_PORT_SPAN) begin
            l.hit  = 1'b1;
            l.pair = 2'(n);
            l.off  = d[2:0];
         end
      end
      return l;
   endfunction

   // final target of an access, with any pointer step it implies
   function automatic dag_res_s resolve(input logic [11:0]      a,
                                        input logic             wr,
                                        input logic [2:0][11:0] ptr,
                                        input logic [7:0]       acc);
      dag_res_s    r;
      dag_loc_s    l;
      dag_loc_s    t;
      logic [11:0] p;
      r      = '0;
      r.tgt  = TGT_MEM;
      r.addr = a;
      l      = locate(a);
      t      = l;
      if (l.hit && l.off <= `DAG_OFF_PLUS_ACC) begin
         p           = ptr[l.pair];
         r.step_pair = l.pair;
         // [R10] whole pointer, bank ignored
         r.addr      = p;
         case (l.off)
            // [R11] access then step
            `DAG_OFF_UP_AFTER: begin
               r.do_step = 1'b1;
               r.new_ptr = p + 12'h001;
            end
            // [R16] full 12-bit borrow
            `DAG_OFF_DN_AFTER: begin
               r.do_step = 1'b1;
               r.new_ptr = p - 12'h001;
            end
            // [R12] step before access
            `DAG_OFF_UP_BEFOR: begin
               r.do_step = 1'b1;
               r.new_ptr = p + 12'h001;
               r.addr    = p + 12'h001;
            end
            // [R13] signed accumulator offset
            // [R14] no pointer or acc change
            `DAG_OFF_PLUS_ACC: begin
               r.addr = p + {{4{acc[7]}}, acc};
            end
            // [R15] plain port, no step
            // [R9] memory at the pointer
            default: begin
               r.addr = p;
            end
         endcase
         t = locate(r.addr);
         if (t.hit && t.off <= `DAG_OFF_PLUS_ACC) begin
            // [R18] [R19] nested port: read gives zero but still steps, write has no effect
            r.tgt = TGT_NULL;
            if (wr) begin
               r.do_step = 1'b0;
            end
         end else if (t.hit) begin
            r.tgt = TGT_PTR;
            // [R20] own pair written unstepped
            if (wr && t.pair == l.pair) begin
               r.do_step = 1'b0;
            end
         end
      end else if (l.hit) begin
         // [R21] pointer bytes in register space
         r.tgt = TGT_PTR;
      end
      r.ptr_pair = t.pair;
      r.ptr_high = (t.off == `DAG_OFF_PTR_HIGH);
      return r;
   endfunction

   logic        av_req;
   logic        go;
   logic        wr;
   logic [11:0] ad;
   logic [7:0]  wd;
   logic [7:0]  acc_sel;
   logic [7:0]  file_addr;
   logic [7:0]  val;
   logic [11:0] direct_addr;
   dag_res_s    res;
   logic [31:0] rd_mux;

   assign av_req            = I_AVS_READ | I_AVS_WRITE;
   // one idle cycle per access keeps read data from a flip-flop
   assign O_AVS_WAITREQUEST = av_req & ~st.av_ack;
   assign O_AVS_READDATA    = st.av_rdata;
   assign O_DEC_READY       = (st.phase == PH_IDLE) & ~st.av_ack;
   assign O_DEC_DONE        = st.done;
   assign O_DEC_RDATA       = st.rd_data;
   assign O_PROG_TARGET     = st.prog_target;
   assign O_DEST_SRC        = st.dest_src;
   assign O_DEST_ACC        = st.dest_acc;
   assign O_EFF_ADDR        = st.eff_addr;
   assign O_MEM_ADDR        = st.mem_addr;
   assign O_MEM_RD          = st.mem_rd;
   assign O_MEM_WR          = st.mem_wr;
   assign O_MEM_WDATA       = st.mem_wdata;

   // [R3] file address is the opcode low byte
   assign file_addr = I_DEC_OPCODE[7:0];

   always_comb begin
      direct_addr = {`DAG_ACCESS_HIGH, file_addr};
      if (I_DEC_BANK_SEL) begin
         // [R4] [R22] bank nibble over file byte
         direct_addr = {st.bank[3:0], file_addr};
      end else if (st.ext && file_addr < `DAG_ACCESS_SPLIT) begin
         // [R1] indexed offset from pair two
         direct_addr = st.ptr[2] + {4'h0, file_addr};
      end else if (file_addr < `DAG_ACCESS_SPLIT) begin
         // [R5] fixed access bank, bank ignored
         direct_addr = {4'h0, file_addr};
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (I_AVS_ADDRESS)
         `DAG_REG_CTRL: rd_mux[`DAG_CTRL_EXT_BIT] = st.ext;
         `DAG_REG_BANK: rd_mux[7:0] = st.bank;
         `DAG_REG_PTR0: rd_mux[11:0] = st.ptr[0];
         `DAG_REG_PTR1: rd_mux[11:0] = st.ptr[1];
         `DAG_REG_PTR2: rd_mux[11:0] = st.ptr[2];
         `DAG_REG_STATUS: begin
            rd_mux[`DAG_STAT_BUSY] = (st.phase != PH_IDLE);
            rd_mux[`DAG_STAT_ADDR_LO +: 12] = st.eff_addr;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_st        = st;
      next_st.done   = 1'b0;
      next_st.mem_rd = 1'b0;
      next_st.mem_wr = 1'b0;
      go      = 1'b0;
      wr      = 1'b0;
      ad      = 12'h000;
      wd      = 8'h00;
      acc_sel = st.acc;
      val     = 8'h00;
      res     = '0;

      // register bus, answered only while the core is idle
      if (st.av_ack) begin
         next_st.av_ack = 1'b0;
         if (I_AVS_WRITE) begin
            case (I_AVS_ADDRESS)
               `DAG_REG_CTRL: begin
                  if (I_AVS_BYTEENABLE[0]) begin
                     next_st.ext = I_AVS_WRITEDATA[`DAG_CTRL_EXT_BIT];
                  end
               end
               `DAG_REG_BANK: begin
                  if (I_AVS_BYTEENABLE[0]) begin
                     next_st.bank = I_AVS_WRITEDATA[7:0];
                  end
               end
               `DAG_REG_PTR0, `DAG_REG_PTR1, `DAG_REG_PTR2: begin
                  for (int n = 0; n < 3; n++) begin
                     if (I_AVS_ADDRESS == `DAG_REG_PTR0 + 8'(4 * n)) begin
                        if (I_AVS_BYTEENABLE[0]) begin
                           next_st.ptr[n][7:0] = I_AVS_WRITEDATA[7:0];
                        end
                        if (I_AVS_BYTEENABLE[1]) begin
                           next_st.ptr[n][11:8] = I_AVS_WRITEDATA[11:8];
                        end
                     end
                  end
               end
               default: next_st.ext = st.ext;
            endcase
         end
      end else if (av_req && st.phase == PH_IDLE && !I_DEC_VALID) begin
         next_st.av_ack   = 1'b1;
         next_st.av_rdata = I_AVS_READ ? rd_mux : 32'h0000_0000;
      end

      case (st.phase)
         PH_IDLE: begin
            if (I_DEC_VALID && O_DEC_READY) begin
               // [R7] destination bit steers the result
               next_st.dest_src = I_DEC_DEST;
               next_st.dest_acc = ~I_DEC_DEST;
               next_st.acc      = I_DEC_ACC;
               next_st.move     = 1'b0;
               acc_sel          = I_DEC_ACC;
               case (dag_op_e'(I_DEC_OP))
                  OP_LITERAL: begin
                     // [R2] 20-bit program target passed on
                     next_st.prog_target = I_DEC_LITERAL;
                     next_st.done        = 1'b1;
                  end
                  OP_DIRECT: begin
                     go = 1'b1;
                     ad = direct_addr;
                     wr = I_DEC_WRITE;
                     wd = I_DEC_WDATA;
                  end
                  OP_MOVE: begin
                     // [R6] full addresses, bank ignored
                     go           = 1'b1;
                     ad           = I_DEC_MOVE_SRC;
                     next_st.move = 1'b1;
                     next_st.dst  = I_DEC_MOVE_DST;
                  end
                  default: next_st.done = 1'b1;
               endcase
            end
         end
         PH_RD_WAIT: next_st.phase = PH_RD_CAP;
         PH_RD_CAP: begin
            if (st.move) begin
               next_st.wdata = I_MEM_RDATA;
               next_st.phase = PH_WR;
            end else begin
               next_st.rd_data = I_MEM_RDATA;
               next_st.done    = 1'b1;
               next_st.phase   = PH_IDLE;
            end
         end
         PH_WR: begin
            go           = 1'b1;
            wr           = 1'b1;
            ad           = st.dst;
            wd           = st.wdata;
            next_st.move = 1'b0;
         end
         default: next_st.phase = PH_IDLE;
      endcase

      if (go) begin
         res              = resolve(ad, wr, st.ptr, acc_sel);
         next_st.eff_addr = res.addr;
         // [R17] pointer step drives no status flag
         if (res.do_step) begin
            next_st.ptr[res.step_pair] = res.new_ptr;
         end
         case (res.tgt)
            TGT_MEM: begin
               next_st.mem_addr = res.addr;
               if (wr) begin
                  next_st.mem_wr    = 1'b1;
                  next_st.mem_wdata = wd;
               end else begin
                  next_st.mem_rd = 1'b1;
               end
            end
            TGT_PTR: begin
               // [R8] high nibble unused, reads zero
               if (wr && res.ptr_high) begin
                  next_st.ptr[res.ptr_pair][11:8] = wd[3:0];
               end else if (wr) begin
                  next_st.ptr[res.ptr_pair][7:0] = wd;
               end
               val = res.ptr_high ? {4'h0, st.ptr[res.ptr_pair][11:8]}
                                  : st.ptr[res.ptr_pair][7:0];
            end
            default: val = 8'h00;
         endcase
         if (wr) begin
            next_st.done  = 1'b1;
            next_st.phase = PH_IDLE;
         end else if (res.tgt == TGT_MEM) begin
            next_st.phase = PH_RD_WAIT;
         end else if (next_st.move) begin
            next_st.wdata = val;
            next_st.phase = PH_WR;
         end else begin
            next_st.rd_data = val;
            next_st.done    = 1'b1;
            next_st.phase   = PH_IDLE;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         st       <= '0;
         st.phase <= PH_IDLE;
         st.bank  <= `DAG_RST_BANK;
         st.ext   <= `DAG_RST_EXT;
         st.ptr   <= {3{`DAG_RST_PTR}};
      end else begin
         st <= next_st;
      end
   end

endmodule

// ===== verif/dag_ram_model.sv
// data RAM behind the address generator: 4K bytes, one-cycle reads
// assumes one-cycle read and write strobes sampled on the rising edge
`timescale 1ns/1ps
module dag_ram_model (
   input  logic        i_clk,
   input  logic        i_rd,
   input  logic        i_wr,
   input  logic [11:0] i_addr,
   input  logic [7:0]  i_wdata,
   output logic [7:0]  o_rdata
);
   logic [7:0] mem [4096];

   initial begin
      o_rdata = 8'h00;
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'(i) ^ {i[11:8], i[11:8]} ^ 8'h5A;
   end

   // data holds one cycle only, then inverts so a late capture shows
   always @(posedge i_clk) begin
      if (i_wr)
         mem[i_addr] <= i_wdata;
      if (i_rd)
         o_rdata <= mem[i_addr];
      else
         o_rdata <= ~o_rdata;
   end
endmodule

// ===== verif/dag_core_assertions.sv
// port checker of the address generator: bus, decoder and RAM timing
// assumes bind to dag_core; bank and mode bits mirrored from bus writes
`timescale 1ns/1ps
`include "dag_defines.svh"
module dag_core_chk (
   input logic        I_CLK,
   input logic        I_RST_N,
   input logic [7:0]  I_AVS_ADDRESS,
   input logic        I_AVS_READ,
   input logic        I_AVS_WRITE,
   input logic [31:0] I_AVS_WRITEDATA,
   input logic [3:0]  I_AVS_BYTEENABLE,
   input logic [31:0] O_AVS_READDATA,
   input logic        O_AVS_WAITREQUEST,
   input logic        I_DEC_VALID,
   input logic        O_DEC_READY,
   input logic [1:0]  I_DEC_OP,
   input logic [15:0] I_DEC_OPCODE,
   input logic        I_DEC_BANK_SEL,
   input logic        I_DEC_DEST,
   input logic [19:0] I_DEC_LITERAL,
   input logic [11:0] I_DEC_MOVE_SRC,
   input logic [11:0] I_DEC_MOVE_DST,
   input logic        O_DEC_DONE,
   input logic [19:0] O_PROG_TARGET,
   input logic        O_DEST_SRC,
   input logic        O_DEST_ACC,
   input logic [11:0] O_MEM_ADDR,
   input logic        O_MEM_RD,
   input logic        O_MEM_WR
);
   logic        tk;
   logic        bwr;
   logic [1:0]  op;
   logic        a;
   logic        d;
   logic [7:0]  fa;
   logic [11:0] src;
   logic [11:0] dst;
   logic [3:0]  bank;
   logic        ext;

   assign tk = I_DEC_VALID && O_DEC_READY;
   assign bwr = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_BYTEENABLE[0];

   // only the bank's low nibble takes part in forming addresses
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         bank <= 4'h0;
         ext <= 1'b0;
      end else if (bwr && I_AVS_ADDRESS == `DAG_REG_BANK) begin
         bank <= I_AVS_WRITEDATA[3:0];
      end else if (bwr && I_AVS_ADDRESS == `DAG_REG_CTRL) begin
         ext <= I_AVS_WRITEDATA[0];
      end
      if (tk) begin
         op <= I_DEC_OP;
         a <= I_DEC_BANK_SEL;
         d <= I_DEC_DEST;
         fa <= I_DEC_OPCODE[7:0];
         src <= I_DEC_MOVE_SRC;
         dst <= I_DEC_MOVE_DST;
      end
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   a_bus_answer:
      assert property ((I_AVS_READ || I_AVS_WRITE) |-> ##[0:20]
         !O_AVS_WAITREQUEST) else $error("bus access not answered");
   a_unmapped_zero:
      assert property (I_AVS_READ && !O_AVS_WAITREQUEST &&
         I_AVS_ADDRESS > `DAG_REG_STATUS |-> O_AVS_READDATA == '0)
         else $error("unmapped read not zero");
   a_lit_target:
      assert property (tk && I_DEC_OP == 2'd1 |=>
         O_PROG_TARGET == $past(I_DEC_LITERAL))
         else $error("branch target not taken over");
   a_dest_bit:
      assert property (O_DEC_DONE && op == 2'd2 |->
         O_DEST_SRC == d && O_DEST_ACC == !d)
         else $error("destination select wrong");
   a_bank_addr:
      assert property (O_MEM_RD && op == 2'd2 && a && bank != 4'hF |->
         O_MEM_ADDR == {bank, fa}) else $error("banked address wrong");
   a_access_addr:
      assert property (O_MEM_RD && op == 2'd2 && !a && !ext &&
         fa < 8'hD9 |-> O_MEM_ADDR == {(fa < 8'h60) ? 4'h0 : 4'hF, fa})
         else $error("access bank address wrong");
   a_move_src:
      assert property (O_MEM_RD && op == 2'd3 && src[11:8] != 4'hF |->
         O_MEM_ADDR == src) else $error("move source address wrong");
   a_move_dst:
      assert property (O_MEM_WR && op == 2'd3 && dst[11:8] != 4'hF |->
         O_MEM_ADDR == dst) else $error("move target address wrong");
   a_rd_done:
      assert property (O_MEM_RD |-> ##[2:3] O_DEC_DONE)
         else $error("read not completed in time");

   c_move: cover property (tk && I_DEC_OP == 2'd3);
   c_mem_wr: cover property (O_MEM_WR);
   c_bank_wr: cover property (bwr && I_AVS_ADDRESS == `DAG_REG_BANK);
endmodule

bind dag_core dag_core_chk u_chk (.*);

// ===== verif/tb.sv
// self-checking bench of dag_core: bus and decoder driven as sequences
// assumes the RAM model on the memory port and the bound port checker
`timescale 1ns/1ps
`include "dag_defines.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
   logic        I_CLK, I_RST_N, I_AVS_READ, I_AVS_WRITE, I_DEC_VALID;
   logic        I_DEC_BANK_SEL, I_DEC_DEST, I_DEC_WRITE, O_AVS_WAITREQUEST;
   logic        O_DEC_READY, O_DEC_DONE, O_DEST_SRC, O_DEST_ACC;
   logic        O_MEM_RD, O_MEM_WR;
   logic [1:0]  I_DEC_OP;
   logic [3:0]  I_AVS_BYTEENABLE;
   logic [7:0]  I_AVS_ADDRESS, I_DEC_WDATA, I_DEC_ACC, O_DEC_RDATA;
   logic [7:0]  O_MEM_WDATA, I_MEM_RDATA;
   logic [11:0] I_DEC_MOVE_SRC, I_DEC_MOVE_DST, O_EFF_ADDR, O_MEM_ADDR;
   logic [15:0] I_DEC_OPCODE;
   logic [19:0] I_DEC_LITERAL, O_PROG_TARGET;
   logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA, q;
   int          n_errors = 0;
   int          compares = 0;
   int          cyc = 0;

   dag_core u_dut (.*);
   dag_ram_model u_ram (.i_clk(I_CLK), .i_rd(O_MEM_RD), .i_wr(O_MEM_WR),
      .i_addr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA), .o_rdata(I_MEM_RDATA));

   function automatic logic [7:0] pat(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5A;
   endfunction

   task automatic give_verdict;
      if (n_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic av(input logic w, input logic [7:0] a,
                     input logic [11:0] d, input logic [3:0] be);
      @(posedge I_CLK);
      I_AVS_READ <= !w;
      I_AVS_WRITE <= w;
      I_AVS_ADDRESS <= a;
      I_AVS_WRITEDATA <= 32'(d);
      I_AVS_BYTEENABLE <= be;
      do @(posedge I_CLK); while (O_AVS_WAITREQUEST !== 1'b0);
      q = O_AVS_READDATA;
      I_AVS_READ <= 1'b0;
      I_AVS_WRITE <= 1'b0;
   endtask

   task automatic pc(input logic [7:0] a, input logic [11:0] e);
      av(1'b0, a, 12'h000, 4'hF);
      `CHK(q[11:0], e)
   endtask

   task automatic dc(input logic [1:0] op, input logic [7:0] fa,
                     input logic a, input logic w, input logic [7:0] wd);
      @(posedge I_CLK);
      I_DEC_VALID <= 1'b1;
      I_DEC_OP <= op;
      I_DEC_OPCODE <= {8'hA5, fa};
      I_DEC_BANK_SEL <= a;
      I_DEC_WRITE <= w;
      I_DEC_WDATA <= wd;
      do @(posedge I_CLK); while (O_DEC_READY !== 1'b1);
      I_DEC_VALID <= 1'b0;
      do @(posedge I_CLK); while (O_DEC_DONE !== 1'b1);
   endtask

   task automatic dr(input logic a, input logic [7:0] fa,
                     input logic [11:0] ea, input logic [7:0] ed);
      dc(2'd2, fa, a, 1'b0, 8'h00);
      `CHK(O_EFF_ADDR, ea)
      `CHK(O_DEC_RDATA, ed)
   endtask

   initial begin
      I_CLK = 1'b0;
      forever #5 I_CLK = ~I_CLK;
   end

   // generous ceiling: the sequence needs well under a thousand cycles
   always @(posedge I_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         give_verdict;
      end
   end

   initial begin
      {I_RST_N, I_AVS_READ, I_AVS_WRITE, I_DEC_VALID, I_DEC_BANK_SEL} = '0;
      {I_DEC_DEST, I_DEC_WRITE, I_DEC_OP, I_AVS_BYTEENABLE} = '0;
      {I_AVS_ADDRESS, I_AVS_WRITEDATA, I_DEC_OPCODE, I_DEC_WDATA} = '0;
      {I_DEC_ACC, I_DEC_LITERAL, I_DEC_MOVE_SRC, I_DEC_MOVE_DST} = '0;
      repeat (10) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         av(1'b0, 8'(4 * i), 12'h000, 4'hF);
         `CHK(q, 32'h0000_0000)
      end
      av(1'b1, 8'h18, 12'hFFF, 4'hF);
      av(1'b0, 8'h18, 12'h000, 4'hF);
      `CHK(q, 32'h0000_0000)
      av(1'b1, `DAG_REG_BANK, 12'h013, 4'hF);
      dr(1'b1, 8'h45, 12'h345, pat(12'h345));
      dr(1'b0, 8'h45, 12'h045, pat(12'h045));
      dr(1'b0, 8'hA0, 12'hFA0, pat(12'hFA0));
      for (int i = 0; i < 2; i++) begin
         I_DEC_DEST <= i[0];
         dr(1'b1, 8'h46, 12'h346, pat(12'h346));
         `CHK(O_DEST_SRC, i[0])
         `CHK(O_DEST_ACC, !i[0])
      end
      I_DEC_LITERAL <= 20'hA_BCDE;
      dc(2'd0, 8'h00, 1'b0, 1'b0, 8'h00);
      dc(2'd1, 8'h00, 1'b0, 1'b0, 8'h00);
      `CHK(O_PROG_TARGET, 20'hA_BCDE)
      I_DEC_MOVE_SRC <= 12'h123;
      I_DEC_MOVE_DST <= 12'h456;
      dc(2'd3, 8'h00, 1'b1, 1'b0, 8'h00);
      av(1'b1, `DAG_REG_BANK, 12'h004, 4'hF);
      dr(1'b1, 8'h56, 12'h456, pat(12'h123));
      // indirect ports of all three pairs
      av(1'b1, `DAG_REG_PTR1, 12'h2A0, 4'hF);
      dr(1'b0, 8'hE7, 12'h2A0, pat(12'h2A0));
      av(1'b1, `DAG_REG_BANK, 12'h00F, 4'hF);
      dr(1'b1, 8'hE7, 12'h2A0, pat(12'h2A0));
      pc(`DAG_REG_PTR1, 12'h2A0);
      av(1'b1, `DAG_REG_PTR0, 12'h0FF, 4'hF);
      dr(1'b0, 8'hEE, 12'h0FF, pat(12'h0FF));
      pc(`DAG_REG_PTR0, 12'h100);
      dr(1'b0, 8'hED, 12'h100, pat(12'h100));
      pc(`DAG_REG_PTR0, 12'h0FF);
      av(1'b1, `DAG_REG_PTR2, 12'h1FF, 4'hF);
      dr(1'b0, 8'hDC, 12'h200, pat(12'h200));
      pc(`DAG_REG_PTR2, 12'h200);
      av(1'b1, `DAG_REG_PTR1, 12'h300, 4'hF);
      I_DEC_ACC <= 8'h7F;
      dr(1'b0, 8'hE3, 12'h37F, pat(12'h37F));
      I_DEC_ACC <= 8'hFE;
      dr(1'b0, 8'hE3, 12'h2FE, pat(12'h2FE));
      pc(`DAG_REG_PTR1, 12'h300);
      // pointer bytes through direct access and a single bus lane
      dc(2'd2, 8'hE9, 1'b0, 1'b1, 8'h34);
      dc(2'd2, 8'hEA, 1'b0, 1'b1, 8'hA2);
      pc(`DAG_REG_PTR0, 12'h234);
      dc(2'd2, 8'hEA, 1'b0, 1'b0, 8'h00);
      `CHK(O_DEC_RDATA, 8'h02)
      av(1'b1, `DAG_REG_PTR0, 12'hF77, 4'h1);
      pc(`DAG_REG_PTR0, 12'h277);
      // a pointer aimed at another pair's port or its own pair's byte, then indexed offset
      av(1'b1, `DAG_REG_PTR0, 12'hFE7, 4'hF);
      av(1'b1, `DAG_REG_PTR1, 12'h050, 4'hF);
      dc(2'd2, 8'hEF, 1'b0, 1'b0, 8'h00);
      `CHK(O_DEC_RDATA, 8'h00)
      dc(2'd2, 8'hEF, 1'b0, 1'b1, 8'h99);
      dc(2'd2, 8'hEE, 1'b0, 1'b1, 8'h99);
      pc(`DAG_REG_PTR0, 12'hFE7);
      pc(`DAG_REG_PTR1, 12'h050);
      av(1'b1, `DAG_REG_BANK, 12'h000, 4'hF);
      dr(1'b1, 8'h50, 12'h050, pat(12'h050));
      av(1'b1, `DAG_REG_PTR2, 12'hFD9, 4'hF);
      dc(2'd2, 8'hDD, 1'b0, 1'b1, 8'h55);
      pc(`DAG_REG_PTR2, 12'hF55);
      av(1'b1, `DAG_REG_CTRL, 12'h001, 4'hF);
      av(1'b1, `DAG_REG_PTR2, 12'h400, 4'hF);
      dr(1'b0, 8'h10, 12'h410, pat(12'h410));
      av(1'b1, `DAG_REG_CTRL, 12'h000, 4'hF);
      dr(1'b0, 8'h10, 12'h010, pat(12'h010));
      give_verdict;
   end
endmodule
